//--- design/spd_pkg.sv
// package: constants and types for the speed hundredths adjust block
package spd_pkg;
  // ----------------------------------------
  // value layout
  // ----------------------------------------
  localparam int SPD_DIGITS = 4;
  localparam int DIG_W = 4;
  localparam int VAL_W = 16;
  localparam int HUND_LSB = 0;
  localparam int TENTH_LSB = 4;
  localparam int DISP_LSB = 4;
  localparam int DISP_W = 12;
  localparam int SW_W = 8;
  localparam logic [1:0] POS_HUND = 2'h0;
  localparam logic [1:0] POS_TENTH = 2'h1;
  localparam logic [1:0] POS_UNIT = 2'h2;
  localparam logic [1:0] POS_TENS = 2'h3;
  localparam logic [3:0] BCD_ZERO = 4'h0;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_ONE = 4'h1;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] SPEED_RST = 16'h0000;
  localparam logic [11:0] DISP_RST = 12'h000;
  localparam logic [7:0] SW_RST = 8'h00;
  // ----------------------------------------
  // which speed the panel is adjusting
  // ----------------------------------------
  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_ACTIVE = 3'b001,
    TGT_NEXT = 3'b010,
    TGT_CALC = 3'b011,
    TGT_PRESET = 3'b100
  } spd_target_t;
endpackage : spd_pkg

//--- design/spd_step_if.sv
// interface: one digit step request and its stepped result
`timescale 1ns/1ps
interface spd_step_if;
  logic [15:0] cur_val;
  logic [1:0] pos;
  logic up;
  logic clr_hund;
  logic [15:0] nxt_val;
  modport user (output cur_val, output pos, output up, output clr_hund, input nxt_val);
  modport stepper (input cur_val, input pos, input up, input clr_hund, output nxt_val);
endinterface : spd_step_if

//--- design/spd_digit_step.sv
// module: decimal digit step with carry, borrow and hundredths clear
`timescale 1ns/1ps
module spd_digit_step
  import spd_pkg::*;
(
  spd_step_if.stepper st
);
  // ----------------------------------------
  // ripple chain, one digit per stage
  // ----------------------------------------
  wire [SPD_DIGITS-1:0] carry;
  assign carry[0] = 1'b0;
  genvar i;
  for (i = 0; i < SPD_DIGITS; i = i + 1) begin : g_dig
    wire [3:0] d = st.cur_val[i*DIG_W +: DIG_W];
    wire en = (st.pos == 2'(i)) | carry[i];
    wire at_edge = st.up ? (d == BCD_MAX) : (d == BCD_ZERO);
    wire [3:0] inc_d = at_edge ? BCD_ZERO : d + BCD_ONE;
    wire [3:0] dec_d = at_edge ? BCD_MAX : d - BCD_ONE;
    wire [3:0] stepped = st.up ? inc_d : dec_d;
    wire clr = (i == HUND_LSB) && st.clr_hund && (st.pos != POS_HUND);
    if (i < SPD_DIGITS - 1) begin : g_chain
      assign carry[i+1] = en & at_edge;
    end
    // overflow past the tens digit wraps; the panel range keeps users below it
    assign st.nxt_val[i*DIG_W +: DIG_W] = clr ? BCD_ZERO : (en ? stepped : d);
  end
endmodule : spd_digit_step

//--- design/spd_hund_adjust.sv
// module: panel adjustment of speeds held to hundredths resolution
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
module spd_hund_adjust
  import spd_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] sw_inc_pin,
  input wire logic [3:0] sw_dec_pin,
  input wire spd_target_t adjust_target,
  input wire logic hires_option_en,
  input wire logic wide_range_sel,
  input wire logic speed_change_exec,
  output logic [15:0] active_speed,
  output logic [15:0] next_speed,
  output logic [15:0] calc_speed,
  output logic [15:0] preset_speed,
  output logic [11:0] active_speed_disp,
  output logic [11:0] next_speed_disp,
  output logic [11:0] calc_speed_disp,
  output logic [15:0] main_aux_disp,
  output logic [15:0] remote_aux_speed
);

  // ----------------------------------------
  // switch synchronisers
  // ----------------------------------------
  // toggles are raw panel contacts, so two flops before any use
  logic [7:0] sw_meta_reg;
  logic [7:0] sw_sync_reg;
  logic [7:0] sw_prev_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sw_meta_reg <= SW_RST;
      sw_sync_reg <= SW_RST;
      sw_prev_reg <= SW_RST;
    end else begin
      sw_meta_reg <= {sw_dec_pin, sw_inc_pin};
      sw_sync_reg <= sw_meta_reg;
      sw_prev_reg <= sw_sync_reg;
    end
  end

  // ----------------------------------------
  // step decode
  // ----------------------------------------
  // only the leading edge steps, so holding never repeats
  wire [7:0] sw_rise = sw_sync_reg & ~sw_prev_reg;
  wire [3:0] inc_rise = sw_rise[3:0];
  wire [3:0] dec_rise = sw_rise[7:4];
  wire [3:0] pos_hit = inc_rise | dec_rise;
  wire step_valid = |pos_hit;
  // finest digit wins when two toggles land in one cycle
  wire [1:0] step_pos = pos_hit[0] ? POS_HUND :
                        pos_hit[1] ? POS_TENTH :
                        pos_hit[2] ? POS_UNIT : POS_TENS;
  // increment wins over decrement on the same digit
  wire step_up = inc_rise[step_pos];

  // ----------------------------------------
  // acceptance
  // ----------------------------------------
  wire tgt_any = adjust_target != TGT_NONE;
  wire hund_ok = hires_option_en & ~wide_range_sel;
  wire pos_ok = (step_pos != POS_HUND) | hund_ok;
  // a speed change in the same cycle wins; the step is dropped
  wire step_go = step_valid & tgt_any & pos_ok & ~speed_change_exec;

  // ----------------------------------------
  // speed registers
  // ----------------------------------------
  logic [15:0] active_reg;
  logic [15:0] next_reg;
  logic [15:0] calc_reg;
  logic [15:0] preset_reg;
  logic [15:0] active_next;
  logic [15:0] next_next;
  logic [15:0] calc_next;
  logic [15:0] preset_next;

  wire [15:0] sel_val = (adjust_target == TGT_ACTIVE) ? active_reg :
                        (adjust_target == TGT_NEXT) ? next_reg :
                        (adjust_target == TGT_CALC) ? calc_reg : preset_reg;

  spd_step_if step_bus ();

  assign step_bus.cur_val = sel_val;
  assign step_bus.pos = step_pos;
  assign step_bus.up = step_up;
  // coarse step zeros hundredths for active and next
  // coarse step zeros preset hundredths
  // only a targeted speed is ever written, so clear only then
  assign step_bus.clr_hund = tgt_any;

  spd_digit_step u_step (
    .st (step_bus.stepper)
  );

  wire wr_active = step_go && (adjust_target == TGT_ACTIVE);
  wire wr_next = step_go && (adjust_target == TGT_NEXT);
  wire wr_calc = step_go && (adjust_target == TGT_CALC);
  wire wr_preset = step_go && (adjust_target == TGT_PRESET);

  // full-resolution exchange on a speed change
  // hidden hundredths written back through the stepper
  assign active_next = speed_change_exec ? next_reg :
                       wr_active ? step_bus.nxt_val : active_reg;
  assign next_next = speed_change_exec ? active_reg :
                     wr_next ? step_bus.nxt_val : next_reg;
  assign calc_next = wr_calc ? step_bus.nxt_val : calc_reg;
  assign preset_next = wr_preset ? step_bus.nxt_val : preset_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      active_reg <= SPEED_RST;
      next_reg <= SPEED_RST;
      calc_reg <= SPEED_RST;
      preset_reg <= SPEED_RST;
    end else begin
      active_reg <= active_next;
      next_reg <= next_next;
      calc_reg <= calc_next;
      preset_reg <= preset_next;
    end
  end

  // ----------------------------------------
  // displays
  // ----------------------------------------
  logic [11:0] active_disp_reg;
  logic [11:0] next_disp_reg;
  logic [11:0] calc_disp_reg;
  logic [15:0] main_aux_reg;
  logic [15:0] remote_aux_reg;

  // main displays drop the hundredths digit
  // calc hundredths kept off its display
  wire [11:0] active_disp_next = active_next[DISP_LSB +: DISP_W];
  wire [11:0] next_disp_next = next_next[DISP_LSB +: DISP_W];
  wire [11:0] calc_disp_next = calc_next[DISP_LSB +: DISP_W];
  // aux shows preset with hundredths while it is set
  wire [15:0] main_aux_next = (adjust_target == TGT_PRESET) ? preset_reg : SPEED_RST;
  // remote aux keeps hundredths only with the option
  wire [15:0] remote_aux_next = hires_option_en ? active_reg :
                                {active_reg[VAL_W-1:TENTH_LSB], BCD_ZERO};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      active_disp_reg <= DISP_RST;
      next_disp_reg <= DISP_RST;
      calc_disp_reg <= DISP_RST;
      main_aux_reg <= SPEED_RST;
      remote_aux_reg <= SPEED_RST;
    end else begin
      active_disp_reg <= active_disp_next;
      next_disp_reg <= next_disp_next;
      calc_disp_reg <= calc_disp_next;
      main_aux_reg <= main_aux_next;
      remote_aux_reg <= remote_aux_next;
    end
  end

  assign active_speed = active_reg;
  assign next_speed = next_reg;
  assign calc_speed = calc_reg;
  assign preset_speed = preset_reg;
  assign active_speed_disp = active_disp_reg;
  assign next_speed_disp = next_disp_reg;
  assign calc_speed_disp = calc_disp_reg;
  assign main_aux_disp = main_aux_reg;
  assign remote_aux_speed = remote_aux_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_hund_lockout_opt: assert property (
    (step_valid && step_pos == POS_HUND && !hires_option_en && !speed_change_exec)
    |=> ($stable(active_reg) && $stable(next_reg)))
    else $error("hundredths step taken without option");

  a_wide_range_lock: assert property (
    (step_valid && step_pos == POS_HUND && wide_range_sel && !speed_change_exec)
    |=> ($stable(active_reg) && $stable(next_reg) && $stable(calc_reg)))
    else $error("hundredths step taken in wide range");

  a_hund_step_up: assert property (
    (step_go && step_pos == POS_HUND && step_up && adjust_target == TGT_NEXT
     && next_reg[3:0] != BCD_MAX)
    |=> (next_reg[3:0] == $past(next_reg[3:0]) + BCD_ONE
         && next_reg[15:4] == $past(next_reg[15:4])))
    else $error("next hundredths did not step by one");

  a_hund_carry_tenth: assert property (
    (step_go && step_pos == POS_HUND && step_up && adjust_target == TGT_ACTIVE
     && active_reg[3:0] == BCD_MAX && active_reg[7:4] != BCD_MAX)
    |=> (active_reg[3:0] == BCD_ZERO
         && active_reg[7:4] == $past(active_reg[7:4]) + BCD_ONE)
        ##1 (active_disp_reg[3:0] == active_reg[7:4]))
    else $error("hundredths carry into tenths wrong");

  a_hund_borrow: assert property (
    (step_go && step_pos == POS_HUND && !step_up && adjust_target == TGT_ACTIVE
     && active_reg[3:0] == BCD_ZERO && active_reg[7:4] != BCD_ZERO)
    |=> (active_reg[3:0] == BCD_MAX
         && active_reg[7:4] == $past(active_reg[7:4]) - BCD_ONE))
    else $error("hundredths borrow from tenths wrong");

  a_remote_hund_res: assert property (
    (hires_option_en && $stable(active_reg))
    |=> (remote_aux_reg == $past(active_reg)))
    else $error("remote aux lost hundredths");

  a_coarse_clear_act: assert property (
    (step_go && step_pos != POS_HUND && adjust_target == TGT_ACTIVE)
    |=> (active_reg[3:0] == BCD_ZERO))
    else $error("coarse step left active hundredths");

  a_speed_swap: assert property (
    speed_change_exec
    |=> (active_reg == $past(next_reg) && next_reg == $past(active_reg)))
    else $error("speed change did not swap at full resolution");

  a_no_auto_repeat: assert property (
    (sw_sync_reg[0] && sw_sync_reg == sw_prev_reg && !speed_change_exec)
    |=> ($stable(active_reg) && $stable(next_reg)
         && $stable(calc_reg) && $stable(preset_reg)))
    else $error("held hundredths toggle repeated");

  a_calc_hund_step: assert property (
    (step_go && step_pos == POS_HUND && step_up && adjust_target == TGT_CALC
     && calc_reg[3:0] != BCD_MAX)
    |=> (calc_reg[3:0] == $past(calc_reg[3:0]) + BCD_ONE)
        ##1 (calc_disp_reg == calc_reg[15:4]))
    else $error("calc hundredths step wrong");

  a_calc_coarse_clear: assert property (
    (step_go && step_pos != POS_HUND && adjust_target == TGT_CALC)
    |=> (calc_reg[3:0] == BCD_ZERO))
    else $error("coarse step left calc hundredths");

  a_preset_aux_show: assert property (
    (adjust_target == TGT_PRESET)
    |=> (main_aux_reg == $past(preset_reg)))
    else $error("preset not shown in main aux");

  a_preset_coarse_clr: assert property (
    (step_go && step_pos != POS_HUND && adjust_target == TGT_PRESET)
    |=> (preset_reg[3:0] == BCD_ZERO))
    else $error("coarse step left preset hundredths");

  a_coarse_clear_next: assert property (
    (step_go && step_pos != POS_HUND && adjust_target == TGT_NEXT)
    |=> (next_reg[3:0] == BCD_ZERO))
    else $error("coarse step left next hundredths");

  a_active_hund_up: assert property (
    (step_go && step_pos == POS_HUND && step_up && adjust_target == TGT_ACTIVE
     && active_reg[3:0] != BCD_MAX)
    |=> (active_reg[3:0] == $past(active_reg[3:0]) + BCD_ONE
         && active_reg[15:4] == $past(active_reg[15:4])))
    else $error("active hundredths did not step by one");

  a_calc_hund_down: assert property (
    (step_go && step_pos == POS_HUND && !step_up && adjust_target == TGT_CALC
     && calc_reg[3:0] != BCD_ZERO)
    |=> (calc_reg[3:0] == $past(calc_reg[3:0]) - BCD_ONE
         && calc_reg[15:4] == $past(calc_reg[15:4])))
    else $error("calc hundredths did not step down by one");

  a_preset_hund_step: assert property (
    (step_go && step_pos == POS_HUND && step_up && adjust_target == TGT_PRESET
     && preset_reg[3:0] != BCD_MAX)
    |=> (preset_reg[3:0] == $past(preset_reg[3:0]) + BCD_ONE
         && preset_reg[15:4] == $past(preset_reg[15:4])))
    else $error("preset hundredths did not step by one");

  a_remote_no_opt: assert property (
    !hires_option_en
    |=> (remote_aux_reg[3:0] == BCD_ZERO
         && remote_aux_reg[15:4] == $past(active_reg[15:4])))
    else $error("remote aux showed hundredths without option");

  a_swap_drops_step: assert property (
    speed_change_exec
    |=> ($stable(calc_reg) && $stable(preset_reg)))
    else $error("step taken during speed change");

endmodule : spd_hund_adjust

//--- bench/spd_panel_model.sv
// bench: navigator model of the front-panel "+/-" toggle switches
`timescale 1ns/1ps
module spd_panel_model
  import spd_pkg::*;
(
  input wire logic clock,
  output logic [3:0] sw_inc_pin,
  output logic [3:0] sw_dec_pin
);
  // ----------------------------------------
  // switch handling
  // ----------------------------------------
  // released toggles sit low, never at the last driven level
  initial begin
    sw_inc_pin = 4'h0;
    sw_dec_pin = 4'h0;
  end

  task automatic press(input logic [1:0] pos, input logic up, input int hold);
    @(posedge clock);
    if (up) begin
      sw_inc_pin[pos] <= 1'b1;
    end else begin
      sw_dec_pin[pos] <= 1'b1;
    end
    repeat (hold) @(posedge clock);
    sw_inc_pin <= 4'h0;
    sw_dec_pin <= 4'h0;
    // low long enough for the synchroniser to see the release
    repeat (3) @(posedge clock);
  endtask : press
endmodule : spd_panel_model

//--- bench/spd_hund_adjust_tb.sv
// bench: self-checking testbench for the speed hundredths adjust block
`timescale 1ns/1ps
module spd_hund_adjust_tb;
  import spd_pkg::*;
  // ----------------------------------------
  // stimulus and observation signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  spd_target_t adjust_target = TGT_NONE;
  logic hires_option_en = 1'b0;
  logic wide_range_sel = 1'b0;
  logic speed_change_exec = 1'b0;
  logic [3:0] sw_inc_pin;
  logic [3:0] sw_dec_pin;
  logic [15:0] active_speed, next_speed, calc_speed, preset_speed;
  logic [11:0] active_speed_disp, next_speed_disp, calc_speed_disp;
  logic [15:0] main_aux_disp, remote_aux_speed;
  logic [15:0] exp_a = 16'h0000, exp_n = 16'h0000, exp_c = 16'h0000, exp_p = 16'h0000;
  logic [63:0] prev_all = 64'h0, note;
  logic [63:0] notes [$];
  int mismatches = 0;
  int n_compared = 0;
  integer seed = 88;
  spd_target_t tl [5] = '{TGT_NONE, TGT_ACTIVE, TGT_NEXT, TGT_CALC, TGT_PRESET};

  initial begin
    forever #50 clock = ~clock;
  end

  spd_panel_model spd_panel_model_i (.clock(clock), .sw_inc_pin(sw_inc_pin),
    .sw_dec_pin(sw_dec_pin));

  spd_hund_adjust spd_hund_adjust_i (.clock(clock), .sys_rst(sys_rst),
    .sw_inc_pin(sw_inc_pin), .sw_dec_pin(sw_dec_pin), .adjust_target(adjust_target),
    .hires_option_en(hires_option_en), .wide_range_sel(wide_range_sel),
    .speed_change_exec(speed_change_exec), .active_speed(active_speed),
    .next_speed(next_speed), .calc_speed(calc_speed), .preset_speed(preset_speed),
    .active_speed_disp(active_speed_disp), .next_speed_disp(next_speed_disp),
    .calc_speed_disp(calc_speed_disp), .main_aux_disp(main_aux_disp),
    .remote_aux_speed(remote_aux_speed));

  // ----------------------------------------
  // comparison and reference model
  // ----------------------------------------
  task automatic compare_speed(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare_speed

  task automatic compare_disp(input logic [67:0] got, input logic [67:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare_disp

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // decimal step: coarser digits zero hundredths, carry and borrow ripple up
  function automatic logic [15:0] step(input logic [15:0] v, input logic [1:0] pos,
                                       input logic up);
    logic [15:0] r;
    int i;
    r = v;
    if (pos != POS_HUND) r[3:0] = 4'h0;
    for (i = pos; i < 4; i++) begin
      if (up && r[i*4+:4] != 4'h9) begin
        r[i*4+:4] = r[i*4+:4] + 4'h1;
        break;
      end else if (!up && r[i*4+:4] != 4'h0) begin
        r[i*4+:4] = r[i*4+:4] - 4'h1;
        break;
      end
      r[i*4+:4] = up ? 4'h0 : 4'h9;
    end
    return r;
  endfunction : step

  // display outputs follow the expected speeds
  task automatic check_disp();
    logic [15:0] aux;
    logic [15:0] rem;
    aux = (adjust_target == TGT_PRESET) ? exp_p : 16'h0000;
    rem = hires_option_en ? exp_a : {exp_a[15:4], 4'h0};
    compare_speed({notes.size(), 32'h0000_0000}, 64'h0);
    compare_disp({active_speed_disp, next_speed_disp, calc_speed_disp, main_aux_disp,
                  remote_aux_speed}, {exp_a[15:4], exp_n[15:4], exp_c[15:4], aux, rem});
  endtask : check_disp

  // result watcher: every speed change must match the oldest note
  always @(posedge clock) begin
    if ({active_speed, next_speed, calc_speed, preset_speed} !== prev_all) begin
      note = (notes.size() != 0) ? notes.pop_front() : prev_all;
      compare_speed({active_speed, next_speed, calc_speed, preset_speed}, note);
    end
    prev_all = {active_speed, next_speed, calc_speed, preset_speed};
  end

  // ----------------------------------------
  // driving tasks
  // ----------------------------------------
  task automatic set_opt(input logic h, input logic w);
    @(posedge clock);
    hires_option_en <= h;
    wide_range_sel <= w;
    @(posedge clock);
  endtask : set_opt

  task automatic apply(input spd_target_t t, input logic [1:0] pos, input logic up,
                       input int hold);
    logic ok;
    ok = (t != TGT_NONE) && (pos != POS_HUND || (hires_option_en && !wide_range_sel));
    adjust_target <= t;
    @(posedge clock);
    if (ok) begin
      case (t)
        TGT_ACTIVE: exp_a = step(exp_a, pos, up);
        TGT_NEXT: exp_n = step(exp_n, pos, up);
        TGT_CALC: exp_c = step(exp_c, pos, up);
        default: exp_p = step(exp_p, pos, up);
      endcase
      notes.push_back({exp_a, exp_n, exp_c, exp_p});
    end
    spd_panel_model_i.press(pos, up, hold);
    repeat (3) @(posedge clock);
    check_disp();
  endtask : apply

  // n consecutive exec cycles, each one a full swap
  task automatic swap(input int n);
    repeat (n) begin
      {exp_a, exp_n} = {exp_n, exp_a};
      notes.push_back({exp_a, exp_n, exp_c, exp_p});
    end
    speed_change_exec <= 1'b1;
    repeat (n) @(posedge clock);
    speed_change_exec <= 1'b0;
    repeat (4) @(posedge clock);
    check_disp();
  endtask : swap

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    apply(TGT_ACTIVE, POS_HUND, 1'b1, 2);
    apply(TGT_NEXT, POS_HUND, 1'b0, 2);
    apply(TGT_ACTIVE, POS_TENTH, 1'b1, 2);
    set_opt(1'b1, 1'b0);
    for (int k = 0; k < 10; k++) apply(TGT_ACTIVE, POS_HUND, 1'b1, 1 + k % 3);
    apply(TGT_ACTIVE, POS_HUND, 1'b0, 1);
    // hidden hundredths now nonzero: option off must blank it on the remote aux
    set_opt(1'b0, 1'b0);
    repeat (2) @(posedge clock);
    check_disp();
    set_opt(1'b1, 1'b0);
    apply(TGT_ACTIVE, POS_HUND, 1'b1, 40);
    for (int k = 0; k < 3; k++) apply(TGT_NEXT, POS_HUND, 1'b1, 1);
    apply(TGT_NEXT, POS_UNIT, 1'b1, 1);
    apply(TGT_NEXT, POS_HUND, 1'b1, 1);
    swap(1);
    swap(2);
    apply(TGT_ACTIVE, POS_TENS, 1'b0, 1);
    for (int t = 3; t < 5; t++) begin
      for (int p = 0; p < 4; p++) begin
        apply(tl[t], POS_HUND, 1'b1, 1);
        apply(tl[t], 2'(p), p[0], 1);
      end
    end
    set_opt(1'b1, 1'b1);
    apply(TGT_ACTIVE, POS_HUND, 1'b1, 1);
    apply(TGT_PRESET, POS_HUND, 1'b1, 1);
    set_opt(1'b1, 1'b0);
    apply(TGT_NONE, POS_TENTH, 1'b1, 1);
    // random traffic over all targets, digits and directions
    repeat (40) begin
      apply(tl[$unsigned($random(seed)) % 5], 2'($random(seed)), 1'($random(seed)),
            1 + $unsigned($random(seed)) % 8);
      if (exp_a !== exp_n && 3'($random(seed)) == 3'h0) swap(1);
    end
    tally_and_finish();
  end
endmodule : spd_hund_adjust_tb
